/* File: dv/segment_display_phase_driver_bench.sv */
`default_nettype none
module segment_display_phase_driver_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 2;  // short phases keep the run brief
  logic       mclk, nrst, regWr, regRd, staticMode, segLit;  // clock, reset, strobes, flags
  logic [3:0] regAddr;     // register address
  logic [7:0] regWdata, regRdata, phaseHot;  // bus data, current phase
  logic [4:0] pinOe, pinOn;  // pin drive and activity
  logic [9:0] pinLevel;    // bias levels
  int         mismatches;  // failed compares
  int         cmp_count;   // compares made
  logic [7:0] wf [5] = '{8'h55, 8'haa, 8'hc7, 8'h3c, 8'h81};  // bytes for pins 27..31
  spd_driver #(.PHASE_CYCLES(PC)) u_dut (.mclk(mclk), .nrst(nrst), .ce(1'b1),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .pinOe(pinOe), .pinOn(pinOn), .pinLevel(pinLevel),
    .phaseHot(phaseHot), .staticMode(staticMode));
  spd_glass u_glass (.pinLevel(pinLevel), .segLit(segLit));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one bus cycle; the next call starts 1 ns after the taking edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    regWr    <= wr;
    regRd    <= !wr;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(regRdata, exp);
  endtask : rd
  task automatic rst;
    nrst <= 1'b0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    #1;
  endtask : rst
  // bounded wait for the phase to leave old
  task automatic waitchg(input logic [7:0] old);
    int n;
    n = 0;
    while (phaseHot === old && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 40) begin
      mismatches++;
      end_of_test();
    end
  endtask : waitchg
  initial begin
    mismatches = 0;
    cmp_count  = 0;
    nrst       = 1'b0;
    regWr      = 1'b0;
    regRd      = 1'b0;
    regAddr    = 4'h0;
    regWdata   = 8'h00;
    rst();
    rd(spd_pkg::ADDR_CTRL0, spd_pkg::CTRL0_RST);
    rd(spd_pkg::ADDR_PEN, {3'h0, spd_pkg::PEN_RST});
    rd(spd_pkg::ADDR_BPSEL, {3'h0, spd_pkg::BPSEL_RST});
    rd(4'hf, 8'h00);
    for (int i = 0; i < 5; i++) bus(1'b1, spd_pkg::ADDR_WF27 + 4'(i), wf[i]);
    for (int i = 0; i < 5; i++) rd(spd_pkg::ADDR_WF27 + 4'(i), wf[i]);
    rst();
    for (int i = 0; i < 5; i++) rd(spd_pkg::ADDR_WF27 + 4'(i), wf[i]);
    $display("test registers done");
    bus(1'b1, spd_pkg::ADDR_PEN, 8'h07);
    bus(1'b1, spd_pkg::ADDR_BPSEL, 8'h03);
    // every duty: phases in order, pins per phase, wrap, then stop
    for (int d = 0; d < 8; d++) begin
      bus(1'b1, spd_pkg::ADDR_CTRL0, 8'h80 | 8'(d));
      for (int k = 0; k <= d; k++) begin
        waitchg(k == 0 ? 8'h00 : 8'h01 << (k - 1));
        chk(phaseHot, 8'h01 << k);
        @(posedge mclk);
        #1;
        chk({pinOe, pinOn[2:0]}, {5'h07, wf[2][k], wf[1][k], wf[0][k]});
        chk({7'h00, segLit}, {7'h00, wf[0][k] & wf[2][k]});
      end
      if (d > 0) begin
        waitchg(8'h01 << d);
        chk(phaseHot, 8'h01);
      end
      chk({7'h00, staticMode}, {7'h00, d == 0});
      bus(1'b1, spd_pkg::ADDR_CTRL0, 8'(d));
      repeat (3) @(posedge mclk);
      #1;
      chk({3'h0, pinOe}, 8'h00);
      rd(spd_pkg::ADDR_STATUS, 8'h00);
      $display("test duty %0d done", d);
    end
    // blank: frontplane dark though its byte says on
    bus(1'b1, spd_pkg::ADDR_CTRL0, 8'h89);
    waitchg(8'h00);
    @(posedge mclk);
    #1;
    chk({3'h0, pinOn}, 8'h01);
    chk({7'h00, segLit}, 8'h00);
    $display("test blank done");
    end_of_test();
  end
endmodule : segment_display_phase_driver_bench
`default_nettype wire

/* File: dv/spd_driver_chk.sv */
`default_nettype none
module spd_driver_chk #(
  parameter int PHASE_CYCLES = 16  // cycles per phase
) (
  input wire logic       mclk,       // module clock
  input wire logic       nrst,       // sync reset, active low
  input wire logic       ce,         // clock enable
  input wire logic [4:0] pinOe,      // pin driven
  input wire logic [4:0] pinOn,      // segment or backplane active
  input wire logic [9:0] pinLevel,   // bias levels
  input wire logic [7:0] phaseHot,   // current phase
  input wire logic       staticMode  // single backplane duty
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [7:0] prevHot_r;  // phase at the previous edge
  logic [7:0] dwell_r;    // edges since the phase last moved
  logic [9:0] oeWide;     // enable doubled onto each level field
  logic       moved;      // step between two running phases
  assign oeWide = {{2{pinOe[4]}}, {2{pinOe[3]}}, {2{pinOe[2]}}, {2{pinOe[1]}}, {2{pinOe[0]}}};
  assign moved = phaseHot != prevHot_r && prevHot_r != 8'h00 && phaseHot != 8'h00;
  // frozen with ce like the generator, else a stalled phase reads as too long
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prevHot_r <= 8'h00;
      dwell_r   <= 8'h00;
    end else if (ce) begin
      prevHot_r <= phaseHot;
      dwell_r   <= (phaseHot != prevHot_r) ? 8'h00 : dwell_r + 8'h01;
    end
  end
  property p_onehot;
    $onehot0(phaseHot);
  endproperty
  a_onehot: assert property (p_onehot) else $error("phase not one-hot");
  property p_step;
    moved |-> phaseHot == (prevHot_r << 1) || phaseHot == 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("phase out of order");
  property p_dwell;
    moved |-> dwell_r == 8'(PHASE_CYCLES - 1);
  endproperty
  a_dwell: assert property (p_dwell) else $error("phase length wrong");
  property p_static;
    staticMode |-> phaseHot[7:1] == 7'h00;
  endproperty
  a_static: assert property (p_static) else $error("static uses phase beyond A");
  property p_two_lvl;
    staticMode && $past(staticMode) |-> ((pinLevel ^ (pinLevel >> 1)) & 10'h155) == 10'h000;
  endproperty
  a_two_lvl: assert property (p_two_lvl) else $error("static mid level");
  property p_no_on;
    (pinOn & ~pinOe) == 5'h00;
  endproperty
  a_no_on: assert property (p_no_on) else $error("undriven pin active");
  property p_no_lvl;
    (pinLevel & ~oeWide) == 10'h000;
  endproperty
  a_no_lvl: assert property (p_no_lvl) else $error("undriven pin level");
  property p_idle_off;
    $fell(|phaseHot) |-> ##[0:2] pinOe == 5'h00;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("pins kept after stop");
  c_full: cover property (phaseHot == 8'h80);
  c_static: cover property (staticMode && pinOe != 5'h00);
  c_off: cover property ($fell(|phaseHot));
endmodule : spd_driver_chk
bind spd_driver spd_driver_chk #(.PHASE_CYCLES(PHASE_CYCLES)) u_chk (.mclk(mclk), .nrst(nrst),
  .ce(ce), .pinOe(pinOe), .pinOn(pinOn), .pinLevel(pinLevel), .phaseHot(phaseHot),
  .staticMode(staticMode));
`default_nettype wire

/* File: dv/spd_glass.sv */
`default_nettype none
module spd_glass (
  input  wire logic [9:0] pinLevel,  // bias level per pin
  output logic            segLit     // segment between pins 27 and 29 lit
);
  timeunit 1ns;
  timeprecision 1ps;
  // passive glass: only a full three-step difference turns a segment on,
  // one-step differences stay under its threshold
  always_comb begin
    segLit = (pinLevel[1:0] == 2'h3 && pinLevel[5:4] == 2'h0) ||
             (pinLevel[1:0] == 2'h0 && pinLevel[5:4] == 2'h3);
  end
endmodule : spd_glass
`default_nettype wire

/* File: verilog/spd_driver.sv */
// Local design decisions: the address map and the plain strobed port.
`default_nettype none
module spd_driver #(
  parameter int PHASE_CYCLES = spd_pkg::PHASE_TICKS  // clock cycles per phase
) (
  input  wire logic       mclk,      // module clock, 100 MHz
  input  wire logic       nrst,      // synchronous reset, active low
  input  wire logic       ce,        // clock enable, freezes all state when low
  input  wire logic [3:0] regAddr,   // register address
  input  wire logic [7:0] regWdata,  // register write data
  input  wire logic       regWr,     // write strobe
  input  wire logic       regRd,     // read strobe
  output logic      [7:0] regRdata,  // read data, valid the cycle after regRd
  output logic      [4:0] pinOe,     // pin driven by display logic
  output logic      [4:0] pinOn,     // segment on or backplane active now
  output logic      [9:0] pinLevel,  // two-bit bias level per pin
  output logic      [7:0] phaseHot,  // current phase, one-hot, zero when idle
  output logic            staticMode // single-backplane duty in force
);
  localparam int NPIN = spd_pkg::PIN_COUNT;

  initial begin
    if (PHASE_CYCLES < 1 || PHASE_CYCLES > 65535) $error("PHASE_CYCLES out of range");
  end

  // map a bus address onto a waveform byte index; used by write and read
  function automatic logic [3:0] wfIndex(input logic [3:0] a);
    if (a >= spd_pkg::ADDR_WF27 && a <= spd_pkg::ADDR_WF31) begin
      wfIndex = {1'b0, 3'(a - spd_pkg::ADDR_WF27)};
    end else begin
      wfIndex = 4'h8;  // not a waveform byte
    end
  endfunction : wfIndex

  // control state
  logic [7:0]      ctrl0_r;      // display_control_reg0
  logic [NPIN-1:0] pen_r;        // pin_function_enable_reg
  logic [NPIN-1:0] bpsel_r;      // backplane_select_reg
  logic [7:0]      rdOther_r;    // read data for non-waveform registers
  logic            rdFromMem_r;  // last read hit the waveform bytes

  // decoded fields
  logic            moduleEnable; // module_enable_bit
  logic [2:0]      duty;         // duty field
  logic            blank;        // blank display mode
  logic [3:0]      wIdx;         // waveform index of the write address
  logic [3:0]      rIdx;         // waveform index of the read address
  logic            wfWrite;      // write lands in a waveform byte
  logic            wfRead;       // read lands in a waveform byte
  logic [7:0]      memRdata;     // waveform read data, registered in memory

  // phase generator outputs
  logic [2:0]      phaseIdx;     // current phase number
  logic            frameInv;     // polarity for the running frame
  logic            running;      // generator active
  logic [NPIN*8-1:0] wfFlat;     // all waveform bytes

  assign moduleEnable = ctrl0_r[spd_pkg::CTRL_ENABLE];
  assign duty         = ctrl0_r[spd_pkg::CTRL_DUTY_LSB +: 3];
  assign blank        = ctrl0_r[spd_pkg::CTRL_BLANK];
  assign wIdx         = wfIndex(regAddr);
  assign rIdx         = wfIndex(regAddr);
  assign wfWrite      = regWr && !wIdx[3];
  assign wfRead       = regRd && !rIdx[3];

  // control register writes; settings take effect at once, so software is
  // expected to set up before enabling, since mid-frame changes glitch
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl0_r <= spd_pkg::CTRL0_RST;
    end else if (ce && regWr && regAddr == spd_pkg::ADDR_CTRL0) begin
      ctrl0_r <= regWdata;
    end
  end

  // pin enable register
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pen_r <= spd_pkg::PEN_RST;
    end else if (ce && regWr && regAddr == spd_pkg::ADDR_PEN) begin
      pen_r <= regWdata[NPIN-1:0];
    end
  end

  // backplane select register
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bpsel_r <= spd_pkg::BPSEL_RST;
    end else if (ce && regWr && regAddr == spd_pkg::ADDR_BPSEL) begin
      bpsel_r <= regWdata[NPIN-1:0];
    end
  end

  // read path for everything but the waveform bytes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdOther_r   <= 8'h00;
      rdFromMem_r <= 1'b0;
    end else if (ce && regRd) begin
      rdFromMem_r <= wfRead;
      case (regAddr)
        spd_pkg::ADDR_CTRL0: begin
          rdOther_r <= ctrl0_r;
        end
        spd_pkg::ADDR_PEN: begin
          rdOther_r <= {3'h0, pen_r};
        end
        spd_pkg::ADDR_BPSEL: begin
          rdOther_r <= {3'h0, bpsel_r};
        end
        spd_pkg::ADDR_STATUS: begin
          // live generator state, so software can see the sequence run
          rdOther_r <= {running, 3'h0, frameInv, phaseIdx};
        end
        default: begin
          rdOther_r <= 8'h00;  // unmapped or waveform: zero here
        end
      endcase
    end
  end

  // waveform bytes: no reset, byte port only
  spd_wave_mem #(
    .DEPTH (NPIN)
  ) u_mem (
    .mclk  (mclk),
    .ce    (ce),
    .we    (wfWrite),
    .waddr (wIdx[2:0]),
    .wdata (regWdata),
    .re    (wfRead),
    .raddr (rIdx[2:0]),
    .rdata (memRdata),
    .flat  (wfFlat)
  );

  // backplane phase sequencer
  spd_phase_gen #(
    .TICKS (PHASE_CYCLES)
  ) u_pg (
    .mclk     (mclk),
    .nrst     (nrst),
    .ce       (ce),
    .run      (moduleEnable),
    .duty     (duty),
    .phaseIdx (phaseIdx),
    .phaseHot (phaseHot),
    .frameInv (frameInv),
    .running  (running)
  );

  // duty zero gives one backplane and static drive
  assign staticMode = (duty == 3'h0);

  // per-pin drive; registered so pins change on clean edges
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    logic [7:0] wf;        // this pin's waveform byte, bit 0 is phase A
    logic       bitNow;    // waveform bit of the current phase
    logic       isBp;      // pin acts as backplane
    logic       drive;     // pin owned by display logic
    logic       onNxt;     // segment on or backplane active
    logic [1:0] lvlNxt;    // bias level to drive
    logic       oe_r;      // registered enable
    logic       on_r;      // registered state
    logic [1:0] lvl_r;     // registered level

    assign wf     = wfFlat[p*8 +: 8];
    assign bitNow = wf[phaseIdx];
    assign isBp   = bpsel_r[p];
    assign drive  = pen_r[p] && moduleEnable && running;

    // level choice: blank forces frontplanes off but keeps backplanes
    // running, so the glass still sees zero net voltage
    always_comb begin
      onNxt  = 1'b0;
      lvlNxt = spd_pkg::LVL_V0;
      if (isBp) begin
        onNxt = bitNow;
      end else begin
        onNxt = bitNow && !blank;
      end
      if (staticMode) begin
        // two levels only; an off segment follows the backplane
        if (isBp || !onNxt) begin
          lvlNxt = frameInv ? spd_pkg::LVL_V0 : spd_pkg::LVL_V3;
        end else begin
          lvlNxt = frameInv ? spd_pkg::LVL_V3 : spd_pkg::LVL_V0;
        end
      end else if (isBp) begin
        // third bias: active backplane at a rail, idle at an inner level
        if (onNxt) begin
          lvlNxt = frameInv ? spd_pkg::LVL_V0 : spd_pkg::LVL_V3;
        end else begin
          lvlNxt = frameInv ? spd_pkg::LVL_V2 : spd_pkg::LVL_V1;
        end
      end else begin
        // frontplane opposite rail when on, near level when off
        if (onNxt) begin
          lvlNxt = frameInv ? spd_pkg::LVL_V3 : spd_pkg::LVL_V0;
        end else begin
          lvlNxt = frameInv ? spd_pkg::LVL_V1 : spd_pkg::LVL_V2;
        end
      end
    end

    // undriven pins show off and level zero
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        oe_r  <= 1'b0;
        on_r  <= 1'b0;
        lvl_r <= spd_pkg::LVL_V0;
      end else if (ce) begin
        oe_r  <= drive;
        on_r  <= drive && onNxt;
        lvl_r <= drive ? lvlNxt : spd_pkg::LVL_V0;
      end
    end

    assign pinOe[p]          = oe_r;
    assign pinOn[p]          = on_r;
    assign pinLevel[p*2 +: 2] = lvl_r;
  end

  // final read mux; both sources are flops loaded on the same strobe
  logic rdValid_r;  // a read was taken last cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdValid_r <= 1'b0;
    end else if (ce) begin
      rdValid_r <= regRd;
    end
  end

  logic [7:0] rdMux;  // selected read byte
  assign rdMux = !rdValid_r ? 8'h00 : (rdFromMem_r ? memRdata : rdOther_r);
  // read data stand only in the cycle after the strobe; every source is a flop
  assign regRdata = rdMux;
endmodule : spd_driver
`default_nettype wire

/* File: verilog/spd_phase_gen.sv */
`default_nettype none
module spd_phase_gen #(
  parameter int TICKS = spd_pkg::PHASE_TICKS  // cycles per phase
) (
  input  wire logic       mclk,      // module clock
  input  wire logic       nrst,      // sync reset, active low
  input  wire logic       ce,        // clock enable
  input  wire logic       run,       // module enabled
  input  wire logic [2:0] duty,      // duty field
  output logic      [2:0] phaseIdx,  // current phase, 0 is A
  output logic      [7:0] phaseHot,  // one-hot phase, zero when idle
  output logic            frameInv,  // polarity, flips each frame
  output logic            running    // generator active
);
  initial begin
    if (TICKS < 1 || TICKS > 65535) $error("TICKS out of range");
  end

  spd_pkg::spd_pg_state_t state_r;  // idle or running
  logic [15:0]            tick_r;   // cycles spent in current phase
  logic [2:0]             phase_r;  // phase counter
  logic                   inv_r;    // frame polarity
  logic                   lastTick; // end of a phase

  assign lastTick = (tick_r == 16'(TICKS - 1));

  // start on enable, stop at once when enable drops
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= spd_pkg::PG_IDLE;
    end else if (ce) begin
      case (state_r)
        spd_pkg::PG_IDLE: if (run) state_r <= spd_pkg::PG_RUN;
        spd_pkg::PG_RUN:  if (!run) state_r <= spd_pkg::PG_IDLE;
        default:          state_r <= spd_pkg::PG_IDLE;
      endcase
    end
  end

  // phases walk A upward, wrap after the last one the duty allows
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tick_r  <= 16'h0000;
      phase_r <= 3'h0;
      inv_r   <= 1'b0;
    end else if (ce) begin
      if (state_r != spd_pkg::PG_RUN) begin
        tick_r  <= 16'h0000;
        phase_r <= 3'h0;
        inv_r   <= 1'b0;
      end else if (lastTick) begin
        tick_r <= 16'h0000;
        if (phase_r >= duty) begin
          phase_r <= 3'h0;
          inv_r   <= ~inv_r;  // one frame done
        end else begin
          phase_r <= phase_r + 3'h1;
        end
      end else begin
        tick_r <= tick_r + 16'h0001;
      end
    end
  end

  assign running  = (state_r == spd_pkg::PG_RUN);
  assign phaseIdx = phase_r;
  assign frameInv = inv_r;
  assign phaseHot = running ? (8'h01 << phase_r) : 8'h00;
endmodule : spd_phase_gen
`default_nettype wire

/* File: verilog/spd_pkg.sv */
`default_nettype none
package spd_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] ADDR_CTRL0  = 4'h0;  // display_control_reg0
  localparam logic [3:0] ADDR_PEN    = 4'h1;  // pin_function_enable_reg
  localparam logic [3:0] ADDR_BPSEL  = 4'h2;  // backplane_select_reg
  localparam logic [3:0] ADDR_STATUS = 4'h3;  // read-only phase state
  localparam logic [3:0] ADDR_WF27   = 4'h4;  // pin27_segment_phase_map
  localparam logic [3:0] ADDR_WF31   = 4'h8;  // pin31_segment_phase_map
  // display_control_reg0 fields
  localparam int CTRL_DUTY_LSB = 0;  // duty field, bits 2:0
  localparam int CTRL_BLANK    = 3;  // blank display mode
  localparam int CTRL_ENABLE   = 7;  // module_enable_bit
  // status fields
  localparam int STAT_PHASE_LSB = 0;  // current phase index, bits 2:0
  localparam int STAT_INV       = 3;  // frame polarity
  localparam int STAT_RUN       = 7;  // generator running
  // values after reset
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [4:0] PEN_RST   = 5'h00;
  localparam logic [4:0] BPSEL_RST = 5'h00;
  // counts
  localparam int PIN_FIRST   = 27;  // lowest display pin served here
  localparam int PIN_COUNT   = 5;   // pins 27 to 31
  localparam int PHASE_COUNT = 8;   // phases A to H
  localparam int PHASE_TICKS = 16;  // clock cycles per phase, default
  // drive levels on a pin, one of four bias voltages
  localparam logic [1:0] LVL_V0 = 2'h0;
  localparam logic [1:0] LVL_V1 = 2'h1;
  localparam logic [1:0] LVL_V2 = 2'h2;
  localparam logic [1:0] LVL_V3 = 2'h3;
  // phase generator states
  typedef enum logic [1:0] {
    PG_IDLE = 2'b01,
    PG_RUN  = 2'b10
  } spd_pg_state_t;
endpackage : spd_pkg
`default_nettype wire

/* File: verilog/spd_wave_mem.sv */
`default_nettype none
module spd_wave_mem #(
  parameter int DEPTH = spd_pkg::PIN_COUNT  // one byte per pin
) (
  input  wire logic                 mclk,   // module clock
  input  wire logic                 ce,     // clock enable
  input  wire logic                 we,     // write strobe
  input  wire logic [2:0]           waddr,  // write index
  input  wire logic [7:0]           wdata,  // write byte
  input  wire logic                 re,     // read strobe
  input  wire logic [2:0]           raddr,  // read index
  output logic      [7:0]           rdata,  // registered read byte
  output logic      [DEPTH*8-1:0]   flat    // all bytes for the drivers
);
  initial begin
    if (DEPTH < 1 || DEPTH > 8) $error("DEPTH out of range");
  end

  logic [7:0] mem [DEPTH];  // no reset: contents kept, unknown at power up

  // byte writes only; the port is one byte wide so no wide write exists
  always_ff @(posedge mclk) begin
    if (ce && we && (32'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  // read data from a register, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (ce && re) begin
      rdata <= (32'(raddr) < DEPTH) ? mem[raddr] : 8'h00;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_flat
    assign flat[i*8 +: 8] = mem[i];
  end
endmodule : spd_wave_mem
`default_nettype wire
